// *** logic/spsb_pkg.sv ***
// Contract
// [R1] Received byte sets receive-full, optional interrupt
// [R2] Any data read clears receive-full
// [R3] Error enable gates overrun and mode-fault interrupts
// [R4] Overrun keeps old byte, drops new
// [R5] Overrun cleared by status read, data read
// [R6] Mode fault on slave-select misuse
// [R7] Mode fault cleared by status read, data write
// [R8] Shifter load sets transmit-empty, optional interrupt
// [R9] Idle shifter takes written byte quickly
// [R10] Active slave shifter not reloaded mid-transfer
// [R11] Software writes data only when transmit-empty
// [R12] Reset values of flags and enables
// [R13] Mode-fault enable gates setting only
// [R14] Master select pin free without enable
// [R15] Slave select pin always used by slave
// [R16] Baud select picks divisor 2/8/32/128
// [R17] Serial clock equals base clock over 2*divisor
// [R18] Data address splits transmit and receive buffers
// [R19] No read-modify-write on data register
// [R20] Flag set wins over same-cycle clear
package spsb_pkg;

  // ==========================================================================
  // Register map: word index, byte address is index times four
  localparam logic [7:0] IDX_CTRL   = 8'h10;
  localparam logic [7:0] IDX_STATUS = 8'h11;
  localparam logic [7:0] IDX_DATA   = 8'h12;
  localparam int         ADDR_LSB   = 2;
  localparam int         ADDR_MSB   = 9;

  // ==========================================================================
  // Field positions
  localparam int CTRL_RX_IE    = 7;
  localparam int CTRL_MASTER   = 5;
  localparam int CTRL_ENABLE   = 1;
  localparam int CTRL_TX_IE    = 0;
  localparam int STAT_RX_FULL  = 7;
  localparam int STAT_ERR_IE   = 6;
  localparam int STAT_OVERRUN  = 5;
  localparam int STAT_MODE_FAULT_FLAG     = 4;
  localparam int STAT_TX_EMPTY = 3;
  localparam int STAT_MODE_FAULT_FLAG_EN  = 2;
  localparam int STAT_BAUD_HI  = 1;
  localparam int STAT_BAUD_LO  = 0;

  // ==========================================================================
  // Reset values
  localparam logic RST_MASTER   = 1'b1;
  localparam logic RST_TX_EMPTY = 1'b1;
  localparam logic RST_CLEAR    = 1'b0;

  // ==========================================================================
  // Baud divisors and frame
  localparam logic [7:0] BAUD_DIV_0 = 8'h02;
  localparam logic [7:0] BAUD_DIV_1 = 8'h08;
  localparam logic [7:0] BAUD_DIV_2 = 8'h20;
  localparam logic [7:0] BAUD_DIV_3 = 8'h80;
  localparam logic [3:0] LAST_BIT   = 4'h7;

  // ==========================================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    SPSB_IDLE = 2'b00,
    SPSB_MRUN = 2'b01,
    SPSB_SRUN = 2'b10
  } spsb_state_t;

  typedef enum logic [1:0] {
    SPSB_SEL_NONE   = 2'b00,
    SPSB_SEL_CTRL   = 2'b01,
    SPSB_SEL_STATUS = 2'b10,
    SPSB_SEL_DATA   = 2'b11
  } spsb_sel_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spsb_pin_in_t;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spsb_pin_out_t;

  function automatic logic [7:0] baud_div(input logic [1:0] code);
    logic [7:0] d;
    d = BAUD_DIV_0;
    unique case (code)
      2'b00: d = BAUD_DIV_0;
      2'b01: d = BAUD_DIV_1;
      2'b10: d = BAUD_DIV_2;
      2'b11: d = BAUD_DIV_3;
    endcase
    return d;
  endfunction

endpackage

// *** logic/spsb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module spsb_top (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESETN,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic      [31:0]            HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  input  wire spsb_pkg::spsb_pin_in_t SPI_IN,
  output spsb_pkg::spsb_pin_out_t     SPI_OUT,
  output logic                        IRQ,
  output logic                        SS_GPIO
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic                  rx_irq_en;
    logic                  master;
    logic                  enable;
    logic                  tx_irq_en;
    logic                  err_irq_en;
    logic                  mode_fault_flag_en;
    logic [1:0]            baud_sel;
    logic                  rx_full;
    logic                  overrun;
    logic                  mode_fault_flag;
    logic                  tx_empty;
    logic                  arm_overrun;
    logic                  arm_mode_fault_flag;
    logic [7:0]            tx_buf;
    logic [7:0]            rx_buf;
    logic [7:0]            shifter;
    logic                  sh_loaded;
    logic                  in_bit;
    logic [3:0]            bit_cnt;
    spsb_pkg::spsb_state_t state;
    logic [7:0]            div_cnt;
    logic                  sck;
    logic                  sck_prev;
    logic                  wr_pending;
    spsb_pkg::spsb_sel_t   wr_sel;
    logic [31:0]           rdata;
  } spsb_regs_t;

  spsb_regs_t s;
  spsb_regs_t next_s;

  function automatic spsb_pkg::spsb_sel_t decode(input logic [31:0] addr);
    spsb_pkg::spsb_sel_t sel;
    sel = spsb_pkg::SPSB_SEL_NONE;
    if (addr[31:spsb_pkg::ADDR_MSB+1] == '0 && addr[spsb_pkg::ADDR_LSB-1:0] == '0) begin
      unique case (addr[spsb_pkg::ADDR_MSB:spsb_pkg::ADDR_LSB])
        spsb_pkg::IDX_CTRL:   sel = spsb_pkg::SPSB_SEL_CTRL;
        spsb_pkg::IDX_STATUS: sel = spsb_pkg::SPSB_SEL_STATUS;
        spsb_pkg::IDX_DATA:   sel = spsb_pkg::SPSB_SEL_DATA;
        default:              sel = spsb_pkg::SPSB_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [7:0] read_value(input spsb_regs_t r, input spsb_pkg::spsb_sel_t sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (sel)
      spsb_pkg::SPSB_SEL_CTRL: begin
        v[spsb_pkg::CTRL_RX_IE]  = r.rx_irq_en;
        v[spsb_pkg::CTRL_MASTER] = r.master;
        v[spsb_pkg::CTRL_ENABLE] = r.enable;
        v[spsb_pkg::CTRL_TX_IE]  = r.tx_irq_en;
      end
      spsb_pkg::SPSB_SEL_STATUS: begin
        v[spsb_pkg::STAT_RX_FULL]  = r.rx_full;
        v[spsb_pkg::STAT_ERR_IE]   = r.err_irq_en;
        v[spsb_pkg::STAT_OVERRUN]  = r.overrun;
        v[spsb_pkg::STAT_MODE_FAULT_FLAG]     = r.mode_fault_flag;
        v[spsb_pkg::STAT_TX_EMPTY] = r.tx_empty;
        v[spsb_pkg::STAT_MODE_FAULT_FLAG_EN]  = r.mode_fault_flag_en;
        v[spsb_pkg::STAT_BAUD_HI]  = r.baud_sel[1];
        v[spsb_pkg::STAT_BAUD_LO]  = r.baud_sel[0];
      end
      // Receive side only; the transmit buffer is write-only
      spsb_pkg::SPSB_SEL_DATA: v = r.rx_buf;
      spsb_pkg::SPSB_SEL_NONE: v = 8'h00;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Next-state logic
  logic                accept;
  logic                rd_accept;
  spsb_pkg::spsb_sel_t sel;
  logic [7:0]          bd_last;
  logic                sck_rise;
  logic                sck_fall;
  logic                done;
  logic [7:0]          done_byte;

  always_comb begin
    next_s    = s;
    done      = 1'b0;
    done_byte = 8'h00;
    accept    = HSEL && HREADY && (HTRANS == spsb_pkg::HTRANS_NONSEQ);
    rd_accept = accept && !HWRITE;
    sel       = decode(HADDR);
    // Divisor only consulted by the master engine
    // [R16] Divisor from select
    bd_last   = spsb_pkg::baud_div(s.baud_sel) - 8'h01;
    sck_rise  = SPI_IN.sck && !s.sck_prev;
    sck_fall  = !SPI_IN.sck && s.sck_prev;

    next_s.sck_prev   = SPI_IN.sck;
    next_s.wr_pending = accept && HWRITE;
    next_s.wr_sel     = accept ? sel : spsb_pkg::SPSB_SEL_NONE;
    // Read data is registered from the address phase, zero-wait
    next_s.rdata      = rd_accept ? {24'h000000, read_value(s, sel)} : 32'h00000000;

    // Write data phase
    if (s.wr_pending) begin
      unique case (s.wr_sel)
        spsb_pkg::SPSB_SEL_CTRL: begin
          next_s.rx_irq_en = HWDATA[spsb_pkg::CTRL_RX_IE];
          next_s.master    = HWDATA[spsb_pkg::CTRL_MASTER];
          next_s.enable    = HWDATA[spsb_pkg::CTRL_ENABLE];
          next_s.tx_irq_en = HWDATA[spsb_pkg::CTRL_TX_IE];
        end
        spsb_pkg::SPSB_SEL_STATUS: begin
          // Flags are read-only; clearing the enable leaves the flag alone
          // [R13] Enable never clears
          next_s.err_irq_en  = HWDATA[spsb_pkg::STAT_ERR_IE];
          next_s.mode_fault_flag_en     = HWDATA[spsb_pkg::STAT_MODE_FAULT_FLAG_EN];
          next_s.baud_sel[1] = HWDATA[spsb_pkg::STAT_BAUD_HI];
          next_s.baud_sel[0] = HWDATA[spsb_pkg::STAT_BAUD_LO];
        end
        spsb_pkg::SPSB_SEL_DATA: begin
          // [R18] Write goes to transmit buffer
          next_s.tx_buf   = HWDATA[7:0];
          next_s.tx_empty = 1'b0;
          // [R7] Mode fault clear step
          if (s.arm_mode_fault_flag) begin
            next_s.mode_fault_flag     = 1'b0;
            next_s.arm_mode_fault_flag = 1'b0;
          end
        end
        spsb_pkg::SPSB_SEL_NONE: begin
        end
      endcase
    end

    // Read side effects
    if (rd_accept && sel == spsb_pkg::SPSB_SEL_STATUS) begin
      next_s.arm_overrun = s.overrun;
      next_s.arm_mode_fault_flag    = s.mode_fault_flag;
    end
    if (rd_accept && sel == spsb_pkg::SPSB_SEL_DATA) begin
      // [R2] Data read clears
      next_s.rx_full = 1'b0;
      // [R5] Overrun clear step
      if (s.arm_overrun) begin
        next_s.overrun     = 1'b0;
        next_s.arm_overrun = 1'b0;
      end
    end

    // Shift engine
    unique case (s.state)
      spsb_pkg::SPSB_IDLE: begin
        next_s.div_cnt = 8'h00;
        next_s.sck     = 1'b0;
        next_s.bit_cnt = 4'h0;
        if (s.enable && s.master) begin
          next_s.sh_loaded = 1'b0;
          // [R9] Idle master loads at once
          if (!s.tx_empty) begin
            next_s.shifter  = s.tx_buf;
            // [R8] Load sets empty
            next_s.tx_empty = 1'b1;
            next_s.state    = spsb_pkg::SPSB_MRUN;
          end
        end else if (s.enable) begin
          // [R9] Idle slave preloads
          if (SPI_IN.ss_n && !s.sh_loaded && !s.tx_empty) begin
            next_s.shifter   = s.tx_buf;
            next_s.tx_empty  = 1'b1;
            next_s.sh_loaded = 1'b1;
          end
          // [R15] Select always frames slave
          if (!SPI_IN.ss_n) begin
            next_s.state = spsb_pkg::SPSB_SRUN;
          end
        end
      end

      spsb_pkg::SPSB_MRUN: begin
        if (!s.enable || !s.master) begin
          next_s.state = spsb_pkg::SPSB_IDLE;
        end else if (s.div_cnt == bd_last) begin
          // [R17] Half period is divisor cycles
          next_s.div_cnt = 8'h00;
          next_s.sck     = !s.sck;
          if (!s.sck) begin
            next_s.in_bit = SPI_IN.miso;
          end else begin
            next_s.shifter = {s.shifter[6:0], s.in_bit};
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == spsb_pkg::LAST_BIT) begin
              done         = 1'b1;
              done_byte    = {s.shifter[6:0], s.in_bit};
              next_s.state = spsb_pkg::SPSB_IDLE;
            end
          end
        end else begin
          next_s.div_cnt = s.div_cnt + 8'h01;
        end
      end

      spsb_pkg::SPSB_SRUN: begin
        if (!s.enable || s.master) begin
          next_s.state     = spsb_pkg::SPSB_IDLE;
          next_s.sh_loaded = 1'b0;
        end else if (SPI_IN.ss_n) begin
          // Select released; mid-byte release is a fault when the mode-fault enable is set
          // [R6] Slave select rise
          if (s.bit_cnt != 4'h0 && s.mode_fault_flag_en) begin
            next_s.mode_fault_flag = 1'b1;
          end
          next_s.state     = spsb_pkg::SPSB_IDLE;
          next_s.sh_loaded = 1'b0;
        end else if (sck_rise) begin
          next_s.in_bit = SPI_IN.mosi;
        end else if (sck_fall) begin
          next_s.shifter = {s.shifter[6:0], s.in_bit};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt == spsb_pkg::LAST_BIT) begin
            done             = 1'b1;
            done_byte        = {s.shifter[6:0], s.in_bit};
            next_s.bit_cnt   = 4'h0;
            // [R10] Reload only in idle after select release
            next_s.sh_loaded = 1'b0;
          end
        end
      end

      default: begin
        next_s.state = spsb_pkg::SPSB_IDLE;
      end
    endcase

    // Master sees select low: fault, only when enabled to look
    // [R14] Select ignored without enable
    if (s.enable && s.master && s.mode_fault_flag_en && !SPI_IN.ss_n) begin
      // [R6] Master select low
      next_s.mode_fault_flag = 1'b1;
    end

    // Delivery after clears, so a same-cycle read frees the buffer
    // [R20] Set wins over clear
    if (done) begin
      if (next_s.rx_full) begin
        // [R4] Keep old, drop new
        next_s.overrun = 1'b1;
      end else begin
        // [R1] Byte into receive buffer
        next_s.rx_buf  = done_byte;
        next_s.rx_full = 1'b1;
      end
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      s           <= '0;
      // [R12] Reset flag values
      s.master    <= spsb_pkg::RST_MASTER;
      s.tx_empty  <= spsb_pkg::RST_TX_EMPTY;
      s.rx_full   <= spsb_pkg::RST_CLEAR;
      s.overrun   <= spsb_pkg::RST_CLEAR;
      s.mode_fault_flag      <= spsb_pkg::RST_CLEAR;
      s.state     <= spsb_pkg::SPSB_IDLE;
      s.wr_sel    <= spsb_pkg::SPSB_SEL_NONE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign HRDATA    = s.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = spsb_pkg::HRESP_OKAY;

  // [R1] [R8] Receive and transmit requests
  // [R3] Error request gated
  assign IRQ = (s.rx_full && s.rx_irq_en) || (s.tx_empty && s.tx_irq_en) ||
               (s.err_irq_en && (s.overrun || s.mode_fault_flag));

  // [R14] Select pin free in master
  assign SS_GPIO = s.enable && s.master && !s.mode_fault_flag_en;

  assign SPI_OUT.sck_o   = s.sck;
  assign SPI_OUT.sck_oe  = s.enable && s.master;
  assign SPI_OUT.mosi_o  = s.shifter[7];
  assign SPI_OUT.mosi_oe = s.enable && s.master;
  assign SPI_OUT.miso_o  = s.shifter[7];
  assign SPI_OUT.miso_oe = s.enable && !s.master && !SPI_IN.ss_n;

endmodule // spsb_top

`default_nettype wire

// *** tb/spsb_top_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module spsb_top_sva (
  input wire logic                    CORE_CLK,
  input wire logic                    RESETN,
  input wire logic                    HSEL,
  input wire logic [31:0]             HADDR,
  input wire logic [1:0]              HTRANS,
  input wire logic                    HWRITE,
  input wire logic [31:0]             HWDATA,
  input wire logic                    HREADY,
  input wire logic [31:0]             HRDATA,
  input wire logic                    HREADYOUT,
  input wire logic                    HRESP,
  input wire spsb_pkg::spsb_pin_in_t  SPI_IN,
  input wire spsb_pkg::spsb_pin_out_t SPI_OUT,
  input wire logic                    IRQ,
  input wire logic                    SS_GPIO
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic       take;
  logic       rd_ph;
  logic       wr_st;
  logic       rst_d;
  logic       last_sck;
  logic [1:0] baud;
  logic [7:0] cnt;
  logic [7:0] bd;
  assign take = HSEL && HREADY && (HTRANS == spsb_pkg::HTRANS_NONSEQ);
  // Divisor tracks the last baud code written over the bus
  assign bd = 8'h02 << {baud, 1'b0};
  always_ff @(posedge CORE_CLK) begin
    rst_d <= !RESETN;
    rd_ph <= RESETN && take && !HWRITE;
    wr_st <= RESETN && take && HWRITE && (HADDR[9:2] == spsb_pkg::IDX_STATUS);
    last_sck <= SPI_OUT.sck_o;
    cnt <= (SPI_OUT.sck_o != last_sck) ? 8'h00 : cnt + 8'h01;
    if (!RESETN) begin
      baud <= 2'h0;
    end else if (wr_st) begin
      baud <= HWDATA[1:0];
    end
  end
  // ==========
  // Assertions
  bus_okay_a: assert property (HREADYOUT && (HRESP == spsb_pkg::HRESP_OKAY))
    else $error("bus answer not ready or not okay");
  rdata_idle_a: assert property (!rd_ph |-> HRDATA == 32'h0)
    else $error("read data outside a read data phase");
  rdata_byte_a: assert property (rd_ph |-> HRDATA[31:8] == 24'h0)
    else $error("read data above bit 7");
  half_period_a: assert property (last_sck && !SPI_OUT.sck_o |-> cnt == bd - 8'h01)
    else $error("serial clock half period wrong");
  rise_gap_a: assert property ($rose(SPI_OUT.sck_o) |-> $past(SPI_OUT.sck_o, 2) == 1'b0)
    else $error("serial clock low phase too short");
  mosi_hold_a: assert property (SPI_OUT.sck_o && $past(SPI_OUT.sck_o) |-> $stable(SPI_OUT.mosi_o))
    else $error("mosi moved while clock high");
  miso_sel_a: assert property (SPI_OUT.miso_oe |-> !SPI_IN.ss_n)
    else $error("miso driven while not selected");
  reset_quiet_a: assert property (rst_d |-> !IRQ && !SS_GPIO && !SPI_OUT.sck_oe && !SPI_OUT.mosi_oe)
    else $error("outputs active right after reset");
  cover property ($rose(IRQ));
  cover property ($rose(SS_GPIO));
  cover property ($fell(SPI_OUT.sck_o));
endmodule // spsb_top_sva
bind spsb_top spsb_top_sva i_spsb_top_sva (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .SPI_IN(SPI_IN), .SPI_OUT(SPI_OUT), .IRQ(IRQ), .SS_GPIO(SS_GPIO)
);
`default_nettype wire

// *** tb/spsb_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========
// Remote slave: clock idle low, MSB first
module spsb_remote (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte
);
  logic [7:0] sh = 8'h00;
  initial rx_byte = 8'h00;
  always @(negedge sel_n) sh = tx_byte;
  always @(posedge sck) if (!sel_n) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sck) if (!sel_n) sh <= {sh[6:0], ~sh[7]};
  // Deselected line shows the inverse so a stale bit never passes
  assign miso = sel_n ? ~sh[7] : sh[7];
endmodule // spsb_remote
`default_nettype wire

// *** tb/spsb_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("Error at %0t: got %h, expected %h", $time, (a), (b)); \
  end \
end
// ==========
// Bench top
module spsb_top_tb;
  localparam logic [7:0] CT = spsb_pkg::IDX_CTRL;
  localparam logic [7:0] ST = spsb_pkg::IDX_STATUS;
  localparam logic [7:0] DT = spsb_pkg::IDX_DATA;
  logic                    CORE_CLK = 1'b0;
  logic                    RESETN = 1'b0;
  logic                    HSEL = 1'b0;
  logic [31:0]             HADDR = 32'h0;
  logic [1:0]              HTRANS = 2'h0;
  logic                    HWRITE = 1'b0;
  logic [2:0]              HSIZE = 3'h2;
  logic [31:0]             HWDATA = 32'h0;
  logic                    HREADY;
  logic [31:0]             HRDATA;
  logic                    HREADYOUT;
  logic                    HRESP;
  logic                    IRQ;
  logic                    SS_GPIO;
  logic                    ss_n = 1'b1;
  logic                    sck_s = 1'b0;
  logic                    mosi_s = 1'b0;
  logic                    sel_n = 1'b1;
  logic                    miso;
  logic [7:0]              tx_byte = 8'h00;
  logic [7:0]              rx_byte;
  spsb_pkg::spsb_pin_in_t  spi_in;
  spsb_pkg::spsb_pin_out_t spi_out;
  int                      error_cnt = 0;
  int                      samples_checked = 0;

  always #2 CORE_CLK = ~CORE_CLK;
  assign HREADY = HREADYOUT;
  assign spi_in = '{sck: sck_s, mosi: mosi_s, miso: miso, ss_n: ss_n};

  spsb_top i_spsb_top (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SPI_IN(spi_in), .SPI_OUT(spi_out), .IRQ(IRQ),
    .SS_GPIO(SS_GPIO)
  );
  spsb_remote i_spsb_remote (
    .sck(spi_out.sck_o), .mosi(spi_out.mosi_o), .sel_n(sel_n), .tx_byte(tx_byte),
    .miso(miso), .rx_byte(rx_byte)
  );

  // ==========
  // Bus master
  // No own limit: only the watchdog ends a hung wait
  task automatic wait_ready();
    @(posedge CORE_CLK);
    while (HREADY !== 1'b1) begin
      @(posedge CORE_CLK);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    HSEL   <= 1'b1;
    HTRANS <= spsb_pkg::HTRANS_NONSEQ;
    HWRITE <= wr;
    HADDR  <= {22'h0, idx, 2'h0};
    wait_ready();
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, wd};
    wait_ready();
    rd = HRDATA[7:0];
  endtask
  task automatic w(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask
  task automatic r(input logic [7:0] idx, output logic [7:0] v);
    xfer(1'b0, idx, 8'h00, v);
  endtask
  task automatic wait_falls();
    int n;
    int k;
    logic s;
    n = 0;
    k = 0;
    s = spi_out.sck_o;
    while (n < 8 && k < 5000) begin
      @(posedge CORE_CLK);
      if (s === 1'b1 && spi_out.sck_o === 1'b0) n++;
      s = spi_out.sck_o;
      k++;
    end
    `CHK(n, 8)
  endtask
  // Remote master bit: miso seen before the rise, two cycles per phase
  task automatic sck_pulse(input logic b, output logic so);
    so = spi_out.miso_o;
    mosi_s <= b;
    repeat (2) @(posedge CORE_CLK);
    sck_s <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    sck_s <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    logic [7:0] v;
    r(CT, v);
    `CHK(v, 8'h20)
    r(ST, v);
    `CHK(v, 8'h08)
    w(8'h20, 8'hFF);
    r(8'h20, v);
    `CHK(v, 8'h00)
  endtask
  task automatic t_xfer();
    logic [7:0] v;
    logic [7:0] p;
    w(CT, 8'hA2);
    for (int c = 0; c < 4; c++) begin
      p = 8'hC5 - 8'(c * 37);
      w(ST, {6'h0, 2'(c)});
      tx_byte <= p;
      sel_n <= 1'b0;
      w(DT, ~p);
      r(ST, v);
      r(ST, v);
      `CHK(v[3], 1'b1)
      wait_falls();
      `CHK(IRQ, 1'b1)
      r(ST, v);
      `CHK(v, 8'h88 | 8'(c))
      r(DT, v);
      `CHK(v, p)
      `CHK(rx_byte, ~p)
      r(ST, v);
      `CHK(v, 8'h08 | 8'(c))
      `CHK(IRQ, 1'b0)
      sel_n <= 1'b1;
    end
  endtask
  task automatic t_overrun();
    logic [7:0] v;
    w(CT, 8'h22);
    w(ST, 8'h40);
    tx_byte <= 8'h5A;
    sel_n <= 1'b0;
    w(DT, 8'hC3);
    wait_falls();
    `CHK(IRQ, 1'b0)
    sel_n <= 1'b1;
    tx_byte <= 8'h96;
    @(posedge CORE_CLK);
    sel_n <= 1'b0;
    // Second byte only after transmit empty
    w(DT, 8'h69);
    wait_falls();
    sel_n <= 1'b1;
    `CHK(IRQ, 1'b1)
    r(DT, v);
    `CHK(v, 8'h5A)
    r(ST, v);
    `CHK(v, 8'h68)
    r(DT, v);
    r(ST, v);
    `CHK(v, 8'h48)
    `CHK(IRQ, 1'b0)
  endtask
  task automatic t_mode_fault_flag();
    logic [7:0] v;
    w(ST, 8'h00);
    `CHK(SS_GPIO, 1'b1)
    ss_n <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    r(ST, v);
    `CHK(v, 8'h08)
    w(ST, 8'h04);
    repeat (2) @(posedge CORE_CLK);
    r(ST, v);
    `CHK(v, 8'h1C)
    `CHK(SS_GPIO, 1'b0)
    `CHK(IRQ, 1'b0)
    ss_n <= 1'b1;
    w(ST, 8'h00);
    r(ST, v);
    `CHK(v, 8'h18)
    w(DT, 8'h00);
    r(ST, v);
    `CHK(v[4], 1'b0)
    wait_falls();
  endtask
  task automatic t_slave();
    logic [7:0] v;
    logic [7:0] m;
    logic       o;
    r(DT, v);
    w(CT, 8'h02);
    w(ST, 8'h04);
    `CHK(SS_GPIO, 1'b0)
    w(DT, 8'hB4);
    r(ST, v);
    r(ST, v);
    `CHK(v, 8'h0C)
    ss_n <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    m = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      sck_pulse(m[i] ^ 1'b0 ^ (8'h3A >> i), o);
      m[i] = o;
    end
    `CHK(m, 8'hB4)
    r(DT, v);
    `CHK(v, 8'h3A)
    // Selected slave must not reload
    w(DT, 8'h77);
    r(ST, v);
    r(ST, v);
    `CHK(v[3], 1'b0)
    sck_pulse(1'b1, o);
    ss_n <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    r(ST, v);
    `CHK(v[4], 1'b1)
    `CHK(v[3], 1'b1)
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    t_reset();
    t_xfer();
    t_overrun();
    t_mode_fault_flag();
    t_slave();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    error_cnt++;
    report_and_stop();
  end
endmodule // spsb_top_tb
`default_nettype wire
